//--- hw/sah_core.sv
/*
 * Control and read-out logic of an 8-bit successive-approximation
 * converter: start handling, bit sequencing, done flag, tri-state data.
 * Assumes the conversion clock, host strobes and comparator arrive as
 * asynchronous pins, and that the pad ring builds the data wires.
 */
// Notes on behaviour
// - Conversion takes nine conversion clock cycles.
// - Status read puts done flag on bit seven.
// - Status read floats data bits zero to six.
// - Format select high offset binary, low two's complement.
// - Done flag rises on start falling clock edge.
// - Done flag falls on rising edge after last bit.
// - Data floats after read strobe returns high.
// - Select and start low clear register on fall.
// - Active conversion after start high, MSB first.
// - Flag low ready, flag high converting.
// - Result reads float all data lines during conversion; status reads still drive bit seven.
`timescale 1ns/1ps
module sah_core (
  // System clock, reset and freeze.
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Asynchronous pins from the host and the analog side.
  input  wire logic       conv_clk,
  input  wire logic       cs_n,
  input  wire logic       start_n,
  input  wire logic       read_n,
  input  wire logic       result_or_flag_select,
  input  wire logic       output_format_select,
  input  wire logic       comparator_high,
  // Status and data pins; an enable bit is low while that line drives.
  output logic            conversion_done_n,
  output logic [7:0]      data_out,
  output logic [7:0]      data_oe_n,
  // Trial code to the converter network.
  output logic [7:0]      approximation_register
);

  sah_pkg::sah_ctl_t  ctl_raw;
  sah_pkg::sah_ctl_t  ctl;
  sah_pkg::sah_state_t state;
  sah_pkg::sah_state_t next_state;
  logic        clk_lvl;
  logic        clk_prev;
  logic        comp;
  logic [2:0]  bit_idx;
  logic [3:0]  rise_cnt;
  logic [7:0]  next_dout;
  logic [7:0]  next_oe_n;

  assign ctl_raw = '{cs_n: cs_n, start_n: start_n, read_n: read_n,
                     result_or_flag_select: result_or_flag_select,
                     output_format_select: output_format_select};

  // Pin synchronisers for the host strobes and the clock/comparator.
  sah_sync #(.W(5)) u_sync_ctl (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .pin (ctl_raw),
    .q   (ctl)
  );

  sah_sync #(.W(2)) u_sync_ana (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .pin ({conv_clk, comparator_high}),
    .q   ({clk_lvl, comp})
  );

  // Edges of the filtered conversion clock.
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_prev <= 1'b1;
    end else if (ce) begin
      clk_prev <= clk_lvl;
    end
  end

  wire rise_ev   = ce && clk_lvl && !clk_prev;
  wire fall_ev   = ce && !clk_lvl && clk_prev;
  wire clear_req = fall_ev && !ctl.cs_n && !ctl.start_n;
  wire go_ev     = rise_ev && (state == sah_pkg::ST_CLEAR)
                   && ctl.start_n;
  wire last_bit  = (bit_idx == 3'h0);

  // Next state of the sequencer; a new request overrides any state.
  always_comb begin
    next_state = state;
    case (state)
      sah_pkg::ST_IDLE:  next_state = sah_pkg::ST_IDLE;
      sah_pkg::ST_CLEAR: if (go_ev) next_state = sah_pkg::ST_CONV;
      sah_pkg::ST_CONV:  if (rise_ev && last_bit) begin
        next_state = sah_pkg::ST_DONE;
      end
      sah_pkg::ST_DONE:  next_state = sah_pkg::ST_DONE;
      default:           next_state = sah_pkg::ST_IDLE;
    endcase
    if (clear_req) begin
      next_state = sah_pkg::ST_CLEAR;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= sah_pkg::ST_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Approximation register: clear, trial MSB, then one bit per rise.
  always_ff @(posedge clk) begin
    if (rst) begin
      approximation_register <= sah_pkg::SAR_RESET;
      bit_idx                <= 3'h7;
    end else if (clear_req) begin
      approximation_register <= sah_pkg::SAR_RESET;
      bit_idx                <= 3'h7;
    end else if (go_ev) begin
      approximation_register <= sah_pkg::SAR_FIRST;
      bit_idx                <= 3'h7;
    end else if (rise_ev && state == sah_pkg::ST_CONV) begin
      approximation_register[bit_idx] <= comp;
      if (!last_bit) begin
        approximation_register[bit_idx - 3'h1] <= 1'b1;
        bit_idx <= bit_idx - 3'h1;
      end
    end
  end

  // Done flag: high from the clearing fall, low after the last decision.
  always_ff @(posedge clk) begin
    if (rst) begin
      conversion_done_n <= sah_pkg::DONE_RESET;
    end else if (clear_req) begin
      conversion_done_n <= 1'b1;
    end else if (rise_ev && state == sah_pkg::ST_CONV && last_bit) begin
      conversion_done_n <= 1'b0;
    end
  end

  // Rising edges counted from the start of the active part.
  always_ff @(posedge clk) begin
    if (rst || clear_req) begin
      rise_cnt <= 4'h0;
    end else if (go_ev || (rise_ev && state == sah_pkg::ST_CONV)) begin
      rise_cnt <= rise_cnt + 4'h1;
    end
  end

  // Read decode: a selected read with start released.
  wire read_act  = !ctl.cs_n && ctl.start_n && !ctl.read_n;
  wire status_rd = read_act && !ctl.result_or_flag_select;
  wire data_rd   = read_act && ctl.result_or_flag_select
                   && !conversion_done_n;
  wire [7:0] fmt_data = ctl.output_format_select
                   ? approximation_register
                   : {~approximation_register[7],
                      approximation_register[6:0]};

  // Output values and enables; nothing drives unless a read is active.
  always_comb begin
    next_dout = 8'h00;
    next_oe_n = 8'hff;
    if (status_rd) begin
      next_dout[sah_pkg::FLAG_BIT] = conversion_done_n;
      next_oe_n[sah_pkg::FLAG_BIT] = 1'b0;
    end else if (data_rd) begin
      next_dout = fmt_data;
      next_oe_n = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_out  <= 8'h00;
      data_oe_n <= 8'hff;
    end else if (ce) begin
      data_out  <= next_dout;
      data_oe_n <= next_oe_n;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_clear;
    clear_req;
  endsequence

  sequence s_go;
    go_ev;
  endsequence

  a_clear_empties_sar: assert property (
    s_clear |=> approximation_register == sah_pkg::SAR_RESET)
    else $error("register not cleared on start fall");

  a_busy_on_clear: assert property (
    s_clear |=> conversion_done_n ##0 state == sah_pkg::ST_CLEAR)
    else $error("done flag not high after clear");

  a_msb_trial_first: assert property (
    s_go ##1 !clear_req |-> approximation_register == sah_pkg::SAR_FIRST)
    else $error("conversion did not start at MSB");

  a_nine_cycles: assert property (
    $fell(conversion_done_n) |-> rise_cnt == sah_pkg::CONV_CYCLES)
    else $error("conversion length not nine clocks");

  a_done_on_rise: assert property (
    $fell(conversion_done_n) |-> $past(rise_ev) && bit_idx == 3'h0)
    else $error("done fell without final rising edge");

  a_status_on_msb: assert property (
    $past(ce) && $past(status_rd) |->
      data_out[7] == $past(conversion_done_n) && !data_oe_n[7])
    else $error("status bit wrong on line seven");

  a_status_low_float: assert property (
    $past(ce) && $past(status_rd) |-> data_oe_n[6:0] == 7'h7f)
    else $error("low lines driven in status read");

  a_format_select: assert property (
    $past(ce) && $past(data_rd) |-> data_out ==
      ($past(ctl.output_format_select) ? $past(approximation_register)
       : ($past(approximation_register) ^ 8'h80)))
    else $error("output code format wrong");

  a_float_read_high: assert property (
    $past(ce) && $past(ctl.read_n) |-> data_oe_n == 8'hff)
    else $error("lines driven after read ended");

  a_float_busy: assert property (
    $past(ce) && $past(conversion_done_n)
      && $past(ctl.result_or_flag_select) |-> data_oe_n == 8'hff)
    else $error("data driven during conversion");

  a_float_deselect: assert property (
    $past(ce) && $past(ctl.cs_n) |-> data_oe_n == 8'hff)
    else $error("lines driven while deselected");

endmodule : sah_core

//--- hw/sah_pkg.sv
/*
 * Shared types and constants of the converter control and read-out block.
 * Assumes a single system clock; all pin-side signals are asynchronous.
 */
package sah_pkg;

  // Width of the conversion result.
  localparam int unsigned RESULT_W = 8;

  // Bit that carries the status flag during a status read.
  localparam int unsigned FLAG_BIT = 7;

  // Conversion clock rising edges from the start edge to the done edge, both counted.
  localparam logic [3:0] CONV_CYCLES = 4'h9;

  // Reset values of the result and of the done flag (idle reads as ready).
  localparam logic [7:0] SAR_RESET  = 8'h00;
  localparam logic       DONE_RESET = 1'b0;

  // Trial pattern loaded when the active part of a conversion starts.
  localparam logic [7:0] SAR_FIRST  = 8'h80;

  // Host control pins travelling together through the synchroniser.
  typedef struct packed {
    logic cs_n;
    logic start_n;
    logic read_n;
    logic result_or_flag_select;
    logic output_format_select;
  } sah_ctl_t;

  // Conversion sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CLEAR = 2'b01,
    ST_CONV  = 2'b10,
    ST_DONE  = 2'b11
  } sah_state_t;

endpackage : sah_pkg

//--- hw/sah_sync.sv
/*
 * Three-flop synchroniser with agreement filter for a group of pins.
 * Assumes the inputs are asynchronous to clk; the output follows a pin
 * only once the second and third stages agree.
 */
`timescale 1ns/1ps
module sah_sync #(
  parameter int unsigned W = 1
) (
  // Clock, reset and freeze.
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Raw pins and filtered levels.
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Shift stages; only stage two reads stage one. They reset to the same
  // idle-high level as the output, so two agreeing reset stages cannot
  // pull a strobe low, or fake a start, just after reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
    end else if (ce) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Each bit is accepted only while the last two stages agree.
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          q[g] <= 1'b1;
        end else if (ce && (s2[g] == s3[g])) begin
          q[g] <= s3[g];
        end
      end
    end
  endgenerate

endmodule : sah_sync

//--- verif/sah_host_model.sv
/*
 * Far-side model: free-running conversion clock and an ideal comparator.
 * Assumes clk is the 40 MHz system clock and rst is synchronous.
 */
`timescale 1ns/1ps
module sah_host_model #(
  parameter int HALF = 6
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Trial code and analog value under test.
  input  wire logic [7:0] approximation_register,
  input  wire logic [7:0] vin,
  // Pins into the block.
  output logic            conv_clk,
  output logic            comparator_high
);
  int cnt;

  // Each phase lasts HALF clocks, above the four the block needs.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt      <= 0;
      conv_clk <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt      <= 0;
      conv_clk <= ~conv_clk;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // The trial bit is kept while the input is at or above the trial code.
  assign comparator_high = (vin >= approximation_register);
endmodule : sah_host_model

//--- verif/sar_adc_host_interface_tb.sv
/*
 * Self-checking bench for the converter control block.
 * Assumes the block and the far-side model compile before this file.
 */
`timescale 1ns/1ps
module sar_adc_host_interface_tb;
  logic       clk, rst, ce, cs_n, start_n, read_n, rfs, ofs;
  logic       conv_clk, comp_hi, done_n;
  logic [7:0] dout, oe_n, sar, vin;
  logic [7:0] vals [5] = '{8'h00, 8'hff, 8'h5a, 8'h80, 8'h7f};
  int         errors, check_count, cycles, rises;

  sah_core i_sah_core (.clk(clk), .rst(rst), .ce(ce), .conv_clk(conv_clk),
    .cs_n(cs_n), .start_n(start_n), .read_n(read_n),
    .result_or_flag_select(rfs), .output_format_select(ofs),
    .comparator_high(comp_hi), .conversion_done_n(done_n),
    .data_out(dout), .data_oe_n(oe_n), .approximation_register(sar));

  sah_host_model i_sah_host_model (.clk(clk), .rst(rst),
    .approximation_register(sar), .vin(vin), .conv_clk(conv_clk),
    .comparator_high(comp_hi));

  // Clock of 25 ns.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Counts conversion clock rises and cuts a hang short.
  always @(posedge conv_clk) rises++;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      summarize();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle

  // One full conversion with status and data reads around it.
  task automatic convert(input logic [7:0] v);
    int n;
    int r0;
    @(posedge clk);
    vin     <= v;
    cs_n    <= 1'b0;
    start_n <= 1'b0;
    n = 0;
    while (done_n !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, conv_clk}, 8'h00);
    chk(sar, 8'h00);
    @(posedge clk);
    start_n <= 1'b1;
    read_n  <= 1'b0;
    rfs     <= 1'b0;
    r0 = rises;
    settle(6);
    chk(oe_n, 8'h7f);
    chk({7'h00, dout[7]}, 8'h01);
    @(posedge clk);
    rfs <= 1'b1;
    settle(6);
    chk(oe_n, 8'hff);
    @(posedge clk);
    read_n <= 1'b1;
    n = 0;
    while (done_n !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, done_n}, 8'h00);
    chk({7'h00, conv_clk}, 8'h01);
    chk({7'h00, (rises - r0) >= 9}, 8'h01);
    chk(sar, v);
    @(posedge clk);
    read_n <= 1'b0;
    rfs    <= 1'b0;
    settle(6);
    chk(oe_n, 8'h7f);
    chk({7'h00, dout[7]}, 8'h00);
    @(posedge clk);
    rfs <= 1'b1;
    ofs <= 1'b1;
    settle(6);
    chk(oe_n, 8'h00);
    chk(dout, v);
    @(posedge clk);
    ofs <= 1'b0;
    settle(6);
    chk(dout, v ^ 8'h80);
    @(posedge clk);
    cs_n <= 1'b1;
    settle(6);
    chk(oe_n, 8'hff);
    @(posedge clk);
    cs_n <= 1'b0;
    settle(6);
    chk(oe_n, 8'h00);
    @(posedge clk);
    read_n <= 1'b1;
    settle(6);
    chk(oe_n, 8'hff);
  endtask : convert

  // Drops the clock enable in mid-conversion: nothing may move while low.
  task automatic freeze(input logic [7:0] v);
    logic [7:0] held;
    int         n;
    @(posedge clk);
    vin     <= v;
    start_n <= 1'b0;
    n = 0;
    while (done_n !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    start_n <= 1'b1;
    settle(40);
    @(posedge clk);
    ce <= 1'b0;
    settle(2);
    held = sar;
    settle(40);
    chk(sar, held);
    chk({7'h00, done_n}, 8'h01);
    @(posedge clk);
    ce <= 1'b1;
    n = 0;
    while (done_n !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, done_n}, 8'h00);
    chk(sar, v);
  endtask : freeze

  // Resets the block in mid-conversion; it must come back idle and ready.
  task automatic reset_mid(input logic [7:0] v);
    int n;
    @(posedge clk);
    vin     <= v;
    start_n <= 1'b0;
    n = 0;
    while (done_n !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    start_n <= 1'b1;
    settle(40);
    chk({7'h00, done_n}, 8'h01);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    settle(2);
    chk({7'h00, done_n}, 8'h00);
    chk(sar, 8'h00);
    chk(oe_n, 8'hff);
  endtask : reset_mid

  task automatic summarize();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // Reset, idle checks, then a burst of back-to-back conversions.
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    cs_n = 1'b1;
    start_n = 1'b1;
    read_n = 1'b1;
    rfs = 1'b1;
    ofs = 1'b1;
    vin = 8'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    settle(2);
    chk({7'h00, done_n}, 8'h00);
    chk(oe_n, 8'hff);
    chk(sar, 8'h00);
    foreach (vals[i]) convert(vals[i]);
    freeze(8'ha5);
    reset_mid(8'h3c);
    convert(8'h3c);
    summarize();
  end
endmodule : sar_adc_host_interface_tb
